// File: verilog/acvr_regs.vh
// register offsets, fields, reset values and window constants for the adapter control bank
// How it works
// - with window enable set the window lands on the 32-Mbyte region picked by the window field.
// - with responder priority enabled, arbitration uses the responder request line, not commander.
// - suppress seen at the winning cycle aborts the transaction and retries after suppress drops.
// - with multiple interrupt enable set, every logged error raises an interrupt if enabled.
// - the self-test-fail status bit is never affected by the multiple interrupt enable.
// - with multiple interrupt enable clear, only one interrupt until error summary is cleared.
// - with return vector disable set, unsolicited or failed vector fetches get an error reply.
// - with return vector disable clear, those fetches get the stored 14-bit vector.
// - reserved bits of both registers, upper half and two low vector bits, read as zero.
// - enabled window base is E0000000 plus 2000000 times field plus 2000 times vme node id.
// - window enabled with field zero refuses non-register vme-directed commands.
`ifndef ACVR_REGS_VH
`define ACVR_REGS_VH
`define ACVR_OFS_CSR     8'h24
`define ACVR_OFS_RVEC    8'h28
`define ACVR_BIT_WSE     5
`define ACVR_BIT_RPE     4
`define ACVR_BIT_MIE     3
`define ACVR_BIT_RVD     1
`define ACVR_VEC_MSB     15
`define ACVR_VEC_LSB     2
`define ACVR_CSR_RST     4'h0
`define ACVR_VEC_RST     14'h0000
`define ACVR_WIN_BASE    32'hE000_0000
`define ACVR_WIN_FSHIFT  25
`define ACVR_WIN_NSHIFT  13
`endif

// File: verilog/acvr_arb.v
// system bus request line steering with suppress abort and retry
`timescale 1ns/10ps
`default_nettype none
module acvr_arb (
  input  wire clk,
  input  wire sys_rst,
  input  wire responder_priority_enable,
  input  wire xact_req,
  input  wire arb_won,
  input  wire bus_suppress_signal,
  output wire commander_request_line,
  output wire responder_request_line,
  output wire xact_go,
  output reg  xact_abort_r
);
  // ****************************************
  // request and retry
  // ****************************************
  localparam ST_IDLE = 2'b00;
  localparam ST_REQ  = 2'b01;
  localparam ST_WAIT = 2'b10;
  reg [1:0] st_r;
  reg [1:0] st_nxt;
  wire      req_act;
  assign req_act = (st_r == ST_REQ);
  assign commander_request_line = req_act & ~responder_priority_enable;
  assign responder_request_line = req_act & responder_priority_enable;
  assign xact_go = req_act & arb_won & ~bus_suppress_signal;
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (xact_req) begin
          st_nxt = ST_REQ;
        end
      end
      ST_REQ: begin
        if (arb_won & bus_suppress_signal) begin
          st_nxt = ST_WAIT;
        end else if (arb_won) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (!bus_suppress_signal) begin
          st_nxt = ST_REQ;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end
  always @(posedge clk) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      xact_abort_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      xact_abort_r <= req_act & arb_won & bus_suppress_signal;
    end
  end
endmodule
`default_nettype wire

// File: verilog/acvr_top.v
// adapter control bits, return vector register, window decode, interrupt gate, vector reply
`timescale 1ns/10ps
`default_nettype none
`include "acvr_regs.vh"
module acvr_top (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata_r,
  input  wire [13:0] translation_control_register,
  input  wire [3:0]  host_node_id,
  input  wire [3:0]  vme_node_id,
  input  wire        io_cmd_valid,
  input  wire [31:0] io_cmd_addr,
  input  wire        io_cmd_is_csr,
  output reg         io_cmd_hit_r,
  output reg         io_cmd_noack_r,
  output reg  [31:0] window_base_r,
  input  wire        xact_req,
  input  wire        arb_won,
  input  wire        bus_suppress_signal,
  output wire        commander_request_line,
  output wire        responder_request_line,
  output wire        xact_go,
  output wire        xact_abort,
  input  wire        err_log,
  input  wire        self_test_fail,
  input  wire        err_summary,
  input  wire        error_interrupt_message_enable,
  output reg         error_interrupt_message,
  output reg         self_test_fail_r,
  input  wire        vfetch_valid,
  input  wire        vfetch_unsol_or_fail,
  output reg         vfetch_reply_r,
  output reg         read_error_reply,
  output reg  [31:0] vfetch_data_r,
  output wire        window_space_enable,
  output wire        responder_priority_enable,
  output wire        multiple_interrupt_enable,
  output wire        return_vector_disable,
  output wire [13:0] return_vector
);
  // ****************************************
  // registers
  // ****************************************
  reg  [3:0]  csr_r;
  reg  [13:0] vec_r;
  reg         error_interrupt_message_armed_r;
  wire [31:0] csr_rd;
  wire [31:0] vec_rd;
  wire [13:0] window_space_field;
  assign window_space_field        = translation_control_register;
  assign window_space_enable       = csr_r[3];
  assign responder_priority_enable = csr_r[2];
  assign multiple_interrupt_enable = csr_r[1];
  assign return_vector_disable     = csr_r[0];
  assign return_vector             = vec_r;
  assign csr_rd = {26'h000_0000, csr_r[3], csr_r[2], csr_r[1], 1'b0, csr_r[0], 1'b0};
  assign vec_rd = {16'h0000, vec_r, 2'b00};
  always @(posedge clk) begin
    if (sys_rst) begin
      csr_r <= `ACVR_CSR_RST;
      vec_r <= `ACVR_VEC_RST;
      reg_rdata_r <= 32'h0000_0000;
    end else begin
      if (reg_wr && reg_addr == `ACVR_OFS_CSR) begin
        csr_r <= {reg_wdata[`ACVR_BIT_WSE], reg_wdata[`ACVR_BIT_RPE],
                  reg_wdata[`ACVR_BIT_MIE], reg_wdata[`ACVR_BIT_RVD]};
      end
      if (reg_wr && reg_addr == `ACVR_OFS_RVEC) begin
        vec_r <= reg_wdata[`ACVR_VEC_MSB:`ACVR_VEC_LSB];
      end
      if (reg_rd) begin
        case (reg_addr)
          `ACVR_OFS_CSR: begin
            reg_rdata_r <= csr_rd;
          end
          `ACVR_OFS_RVEC: begin
            reg_rdata_r <= vec_rd;
          end
          default: begin
            reg_rdata_r <= 32'h0000_0000;
          end
        endcase
      end
    end
  end
  // ****************************************
  // window decode
  // ****************************************
  wire [31:0] base_nxt;
  wire [31:0] fld_w;
  assign fld_w = window_space_enable ? {18'h0_0000, window_space_field}
                                     : {28'h000_0000, host_node_id};
  assign base_nxt = `ACVR_WIN_BASE + (fld_w << `ACVR_WIN_FSHIFT)
                  + ({28'h000_0000, vme_node_id} << `ACVR_WIN_NSHIFT);
  wire        win_hit;
  wire        bad_zero;
  assign win_hit  = (io_cmd_addr[31:25] == base_nxt[31:25]);
  assign bad_zero = window_space_enable & (window_space_field == 14'h0000);
  always @(posedge clk) begin
    if (sys_rst) begin
      window_base_r  <= `ACVR_WIN_BASE;
      io_cmd_hit_r   <= 1'b0;
      io_cmd_noack_r <= 1'b0;
    end else begin
      window_base_r  <= base_nxt;
      io_cmd_hit_r   <= io_cmd_valid & win_hit & ~(bad_zero & ~io_cmd_is_csr);
      io_cmd_noack_r <= io_cmd_valid & bad_zero & ~io_cmd_is_csr;
    end
  end
  // ****************************************
  // arbitration
  // ****************************************
  acvr_arb u_arb (
    .clk                       (clk),
    .sys_rst                   (sys_rst),
    .responder_priority_enable (responder_priority_enable),
    .xact_req                  (xact_req),
    .arb_won                   (arb_won),
    .bus_suppress_signal       (bus_suppress_signal),
    .commander_request_line    (commander_request_line),
    .responder_request_line    (responder_request_line),
    .xact_go                   (xact_go),
    .xact_abort_r              (xact_abort)
  );
  // ****************************************
  // error interrupt gate
  // ****************************************
  wire error_interrupt_message_fire;
  assign error_interrupt_message_fire = err_log & error_interrupt_message_enable &
                     (multiple_interrupt_enable | (~err_summary & error_interrupt_message_armed_r));
  always @(posedge clk) begin
    if (sys_rst) begin
      error_interrupt_message_armed_r <= 1'b1;
      error_interrupt_message <= 1'b0;
      self_test_fail_r <= 1'b0;
    end else begin
      error_interrupt_message <= error_interrupt_message_fire;
      self_test_fail_r <= self_test_fail;
      if (error_interrupt_message_fire && !multiple_interrupt_enable) begin
        error_interrupt_message_armed_r <= 1'b0;
      end else if (!err_summary) begin
        error_interrupt_message_armed_r <= 1'b1;
      end
    end
  end
  // ****************************************
  // vector fetch reply
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      vfetch_reply_r   <= 1'b0;
      read_error_reply <= 1'b0;
      vfetch_data_r    <= 32'h0000_0000;
    end else begin
      vfetch_reply_r   <= vfetch_valid & vfetch_unsol_or_fail & ~return_vector_disable;
      read_error_reply <= vfetch_valid & vfetch_unsol_or_fail & return_vector_disable;
      if (vfetch_valid && vfetch_unsol_or_fail && !return_vector_disable) begin
        vfetch_data_r <= vec_rd;
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/acvr_properties.sv
// assertions on the adapter control bank ports
`timescale 1ns/10ps
`default_nettype none
// ***
// checker
// ***
module acvr_props (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        io_cmd_valid,
  input wire logic        io_cmd_is_csr,
  input wire logic        io_cmd_hit_r,
  input wire logic        io_cmd_noack_r,
  input wire logic        arb_won,
  input wire logic        bus_suppress_signal,
  input wire logic        xact_abort,
  input wire logic        commander_request_line,
  input wire logic        responder_request_line,
  input wire logic        err_log,
  input wire logic        err_summary,
  input wire logic        error_interrupt_message_enable,
  input wire logic        error_interrupt_message,
  input wire logic        vfetch_valid,
  input wire logic        vfetch_unsol_or_fail,
  input wire logic        vfetch_reply_r,
  input wire logic        read_error_reply,
  input wire logic        window_space_enable,
  input wire logic        responder_priority_enable,
  input wire logic        multiple_interrupt_enable,
  input wire logic        return_vector_disable,
  input wire logic [3:0]  vme_node_id,
  input wire logic [13:0] translation_control_register,
  input wire logic [13:0] return_vector,
  input wire logic [31:0] window_base_r,
  input wire logic [31:0] vfetch_data_r
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_sup_abort: assert property (arb_won && bus_suppress_signal &&
    (commander_request_line || responder_request_line) |=> xact_abort) else $error("no abort");
  a_resp_line: assert property (responder_request_line |->
    responder_priority_enable && !commander_request_line) else $error("wrong line");
  a_multi_error_interrupt_message: assert property (err_log && error_interrupt_message_enable && multiple_interrupt_enable
    |=> error_interrupt_message) else $error("missed interrupt");
  a_single_error_interrupt_message: assert property (err_log && err_summary && !multiple_interrupt_enable
    |=> !error_interrupt_message) else $error("extra interrupt");
  a_vec_err: assert property (vfetch_valid && vfetch_unsol_or_fail && return_vector_disable
    |=> read_error_reply && !vfetch_reply_r) else $error("no error reply");
  a_vec_data: assert property (vfetch_valid && vfetch_unsol_or_fail && !return_vector_disable
    |=> vfetch_reply_r && vfetch_data_r == {16'h0000, $past(return_vector), 2'h0})
    else $error("bad vector");
  a_win_base: assert property (window_space_enable && $past(window_space_enable) |->
    window_base_r == 32'he000_0000 + (32'($past(translation_control_register)) << 25)
    + (32'($past(vme_node_id)) << 13)) else $error("bad window base");
  a_zero_noack: assert property (io_cmd_valid && !io_cmd_is_csr && window_space_enable &&
    translation_control_register == 14'h0000 |=> io_cmd_noack_r && !io_cmd_hit_r)
    else $error("no refusal");
endmodule
bind acvr_top acvr_props u_props (.*);
`default_nettype wire

// File: sim/acvr_cmdr.sv
// system bus arbiter model granting the adapter
`timescale 1ns/10ps
`default_nettype none
// ***
// arbiter
// ***
module acvr_cmdr (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       req,
  input  wire logic       sup_cmd,
  input  wire logic [3:0] lag,
  output var  logic       arb_won,
  output var  logic       bus_suppress_signal
);
  logic [3:0] cnt_r;
  always @(posedge clk) begin
    bus_suppress_signal <= sup_cmd && !sys_rst;
    arb_won <= req && !arb_won && cnt_r == lag && !sys_rst;
    cnt_r <= (req && !arb_won && cnt_r != lag) ? cnt_r + 4'h1 : 4'h0;
  end
endmodule
`default_nettype wire

// File: sim/acvr_bench.sv
// self-checking bench for the adapter control bank
`timescale 1ns/10ps
`default_nettype none
// ***
// bench
// ***
module acvr_bench;
  logic        clk, sys_rst, reg_wr, reg_rd, io_cmd_valid, io_cmd_is_csr, xact_req, arb_won;
  logic        bus_suppress_signal, err_log, self_test_fail, err_summary, error_interrupt_message_enable;
  logic        vfetch_valid, vfetch_unsol_or_fail, io_cmd_hit_r, io_cmd_noack_r, sup_cmd;
  logic        commander_request_line, responder_request_line, xact_go, xact_abort;
  logic        error_interrupt_message, self_test_fail_r, vfetch_reply_r, read_error_reply;
  logic        window_space_enable, responder_priority_enable, multiple_interrupt_enable;
  logic        return_vector_disable;
  logic [3:0]  host_node_id, vme_node_id, lag;
  logic [7:0]  reg_addr;
  logic [13:0] translation_control_register, return_vector;
  logic [31:0] reg_wdata, reg_rdata_r, io_cmd_addr, window_base_r, vfetch_data_r;
  int          bad_count, checked, cyc;
  acvr_top DUT (.*);
  acvr_cmdr u_arb (.clk(clk), .sys_rst(sys_rst), .req(commander_request_line |
    responder_request_line), .sup_cmd(sup_cmd), .lag(lag), .arb_won(arb_won),
    .bus_suppress_signal(bus_suppress_signal));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      close_out;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic close_out;
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata_r, e);
  endtask
  task automatic io(input logic [31:0] a, input logic [1:0] e);
    @(posedge clk) {io_cmd_addr, io_cmd_valid} <= {a, 1'b1};
    @(posedge clk) io_cmd_valid <= 1'b0;
    #1 chk(32'({io_cmd_hit_r, io_cmd_noack_r}), 32'(e));
  endtask
  task automatic elog(input logic e);
    @(posedge clk) err_log <= 1'b1;
    @(posedge clk) err_log <= 1'b0;
    #1 chk(32'(error_interrupt_message), 32'(e));
  endtask
  task automatic vf(input logic [1:0] e);
    @(posedge clk) {vfetch_valid, vfetch_unsol_or_fail} <= 2'h3;
    @(posedge clk) vfetch_valid <= 1'b0;
    #1 chk(32'({vfetch_reply_r, read_error_reply}), 32'(e));
  endtask
  task automatic wev(input logic ab);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < 20 && hit !== 1'b1; n++) begin
      @(posedge clk);
      #1 hit = ab ? xact_abort : xact_go;
    end
    chk(32'(hit), 32'h0000_0001);
  endtask
  task automatic t_regs;
    rd(8'h24, 32'h0000_0000);
    rd(8'h28, 32'h0000_0000);
    wr(8'h28, 32'hffff_ffff);
    rd(8'h28, 32'h0000_fffc);
    wr(8'h24, 32'hffff_ffff);
    rd(8'h24, 32'h0000_003a);
    chk(32'(window_space_enable), 32'h0000_0001);
    chk(32'(responder_priority_enable), 32'h0000_0001);
    chk(32'(multiple_interrupt_enable), 32'h0000_0001);
    chk(32'(return_vector_disable), 32'h0000_0001);
    chk(32'(return_vector), 32'h0000_3fff);
    rd(8'h30, 32'h0000_0000);
  endtask
  task automatic t_window;
    @(posedge clk) {translation_control_register, vme_node_id} <= {14'h0005, 4'h3};
    wr(8'h24, 32'h0000_0020);
    repeat (2) @(posedge clk);
    #1 chk(window_base_r, 32'hea00_6000);
    io(32'hea00_6010, 2'h2);
    @(posedge clk) translation_control_register <= 14'h0000;
    io(32'he000_6010, 2'h1);
    @(posedge clk) io_cmd_is_csr <= 1'b1;
    io(32'he000_6010, 2'h2);
    @(posedge clk) {io_cmd_is_csr, host_node_id} <= {1'b0, 4'h2};
    wr(8'h24, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1 chk(window_base_r, 32'he400_6000);
  endtask
  task automatic t_arb(input logic rp);
    wr(8'h24, {27'h000_0000, rp, 4'h0});
    @(posedge clk) {lag, sup_cmd, xact_req} <= {4'h2, 1'b1, 1'b1};
    repeat (2) @(posedge clk);
    #1 chk(32'({responder_request_line, commander_request_line}), rp ? 2 : 1);
    wev(1'b1);
    @(posedge clk) sup_cmd <= 1'b0;
    wev(1'b0);
    @(posedge clk) xact_req <= 1'b0;
  endtask
  task automatic t_error_interrupt_message;
    wr(8'h24, 32'h0000_0000);
    @(posedge clk) {error_interrupt_message_enable, err_summary} <= 2'h3;
    elog(1'b0);
    @(posedge clk) err_summary <= 1'b0;
    elog(1'b1);
    @(posedge clk) {err_summary, self_test_fail} <= 2'h3;
    elog(1'b0);
    chk(32'(self_test_fail_r), 32'h0000_0001);
    wr(8'h24, 32'h0000_0008);
    elog(1'b1);
    elog(1'b1);
    chk(32'(self_test_fail_r), 32'h0000_0001);
  endtask
  task automatic t_vec;
    wr(8'h28, 32'h0000_1234);
    vf(2'h2);
    chk(vfetch_data_r, 32'h0000_1234);
    wr(8'h24, 32'h0000_0002);
    vf(2'h1);
  endtask
  initial begin
    {reg_wr, reg_rd, io_cmd_valid, io_cmd_is_csr, xact_req, err_log, sup_cmd} = '0;
    {self_test_fail, err_summary, error_interrupt_message_enable, vfetch_valid, vfetch_unsol_or_fail} = '0;
    {reg_addr, reg_wdata, io_cmd_addr, translation_control_register, vme_node_id, lag} = '0;
    {host_node_id, bad_count, checked, cyc} = '0;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs;
    t_window;
    t_arb(1'b0);
    t_arb(1'b1);
    t_error_interrupt_message;
    t_vec;
    close_out;
  end
endmodule
`default_nettype wire
